// file: deferred_action.sv
// One deferred command bit: held while the pump runs, applied once it stops
`timescale 1ns/1ps
module deferred_action (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic req_in,
  input  wire logic running_in,
  output logic      fire_out
);
  logic pend_q;
  logic pend_d;
  logic fire_d;

  assign fire_d = (pend_q | req_in) & ~running_in;
  assign pend_d = (pend_q | req_in) & running_in;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pend_q   <= 1'b0;
      fire_out <= 1'b0;
    end else begin
      pend_q   <= pend_d;
      fire_out <= fire_d;
    end
  end
endmodule : deferred_action

// file: fieldbus_master_model.sv
// Bus master model issuing decoded coil and register requests
`timescale 1ns/1ps
module fieldbus_master_model
  import pump_map_pkg::*;
(
  input  wire logic     clk_in,
  input  wire bus_rsp_s rsp_in,
  output bus_req_s      req_out
);
  initial req_out = '0;
  // Idle fields are inverted so stale values cannot pass for a request
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, q, d,
                      output logic [15:0] rd, output logic e, to);
    to = 1'b1;
    rd = '0;
    e = 1'b0;
    @(posedge clk_in);
    req_out <= '{1'b1, f, a, q, d};
    @(posedge clk_in);
    req_out <= '{1'b0, ~f, ~a, ~q, ~d};
    // The answer stands for the one cycle after the request edge
    for (int i = 0; i < 4 && to; i++) begin
      #1;
      if (rsp_in.valid === 1'b1) begin
        to = 1'b0;
        rd = rsp_in.rdata;
        e = rsp_in.err;
      end else begin
        @(posedge clk_in);
      end
    end
  endtask : xfer
endmodule : fieldbus_master_model

// file: pump_fieldbus_map.sv
// Pump fieldbus coil and input register map
//
// Overview of operation
// R1: Each command bit is its own coil with its own address.
// R2: Coil 0x02FF requests run; coil 0x0300 picks rotation, 1 anticlockwise.
// R3: Writing 1 to coil 0x0301 clears the tachometer counter; 0 does nothing.
// R4: Coil 0x0302 enables bus-supplied min and max speed limits.
// R5: Writing 1 to coil 0x0303 loads the pending calibration factor.
// R6: Read-only 16-bit system status word sits at input register 0x0103.
// R7: Status bits 0..3: running, global error, bus control enabled, door open.
// R8: Bits 6, 7, 9 flag over-temperature, stall, tube burst; unused read 0.
// R9: Bits 10, 11, 12 flag low set point, high set point, fluid level.
// R10: Input status at 0x0114 and output status at 0x0115, read-only.
// R11: Both status words are 16 bits, read with function 0x04.
// R12: An input pulled to 0V reads 1; open or high reads 0.
// R13: Output status bit reads 1 while its output is active.
// R14: Input bits 0..2: remote mode, stop, start.
// R15: Input bits 3..6: dest full, source empty, spill, CCW; rest 0.
// R16: Output bits 0..3 mirror outputs 1..4; bits 4..15 read 0.
// R17: Coils hold 0 after every reset.
// R18: Coil actions while running are remembered and applied once stopped; the code applies the run coil 0x02FF at once.
// R19: Functions 0x01, 0x05 and 0x0F read and write coils.
// R20: Clear and load coils act once per write of 1.
`timescale 1ns/1ps
`include "pump_map_params.svh"
module pump_fieldbus_map
  import pump_map_pkg::*;
(
  input  wire logic                      CLK_IN,
  input  wire logic                      SRST_IN,
  input  wire bus_req_s                  REQ_IN,
  input  wire pump_cond_s                COND_IN,
  input  wire logic [`IN_PIN_COUNT-1:0]  REMOTE_IN_N_IN,
  input  wire logic [`OUT_PIN_COUNT-1:0] OUTPUT_ACTIVE_IN,
  output bus_rsp_s                       RSP_OUT,
  output coil_ctrl_s                     CTRL_OUT
);

  ////////////////////////////////////////////////////////////////////////
  // Decode

  logic [`COIL_COUNT-1:0] coils_q;
  logic [`COIL_COUNT-1:0] coils_d;
  logic [15:0]            sys_word;
  logic [15:0]            in_word;
  logic [15:0]            out_word;
  logic [15:0]            coil_ofs;
  logic [15:0]            coil_end;
  logic                   coil_range_ok;
  logic                   is_rd_coil;
  logic                   is_wr_one;
  logic                   is_wr_many;
  logic                   is_rd_reg;
  logic                   reg_hit;
  logic [15:0]            reg_val;
  logic [15:0]            coil_rd_val;
  logic                   one_val_ok;
  logic                   one_bit;
  logic [`COIL_COUNT-1:0] wr_mask;
  logic [`COIL_COUNT-1:0] wr_bits;
  logic                   req_ok;
  logic [15:0]            rdata_d;
  logic                   rev_clr_req;
  logic                   scale_load_req;
  logic                   rev_clr_fire;
  logic                   scale_load_fire;

  assign is_rd_coil = REQ_IN.func == `FC_READ_COILS;           // [R19]
  assign is_wr_one  = REQ_IN.func == `FC_WRITE_ONE_COIL;       // [R19]
  assign is_wr_many = REQ_IN.func == `FC_WRITE_MANY_COILS;     // [R19]
  assign is_rd_reg  = REQ_IN.func == `FC_READ_INPUT_REGS;      // [R11]

  // Coil window bounds; each coil has its own address
  assign coil_ofs = REQ_IN.addr - `COIL_FIRST;                 // [R1]
  assign coil_end = coil_ofs + (is_wr_one ? 16'h0001 : REQ_IN.qty);
  assign coil_range_ok = (REQ_IN.addr >= `COIL_FIRST) && (coil_ofs < 16'(`COIL_COUNT))
                       && (is_wr_one || REQ_IN.qty != 16'h0000)
                       && (coil_end <= 16'(`COIL_COUNT));

  // Write-one-coil uses FF00 for on and 0000 for off
  assign one_val_ok = (REQ_IN.wdata == 16'hFF00) || (REQ_IN.wdata == 16'h0000);
  assign one_bit    = REQ_IN.wdata == 16'hFF00;

  ////////////////////////////////////////////////////////////////////////
  // Status words

  assign sys_word = {3'b000,
                     COND_IN.level_alert, COND_IN.high_sp, COND_IN.low_sp,    // [R9]
                     COND_IN.tube_burst, 1'b0,                                // [R8]
                     COND_IN.stall, COND_IN.over_temp, 2'b00,                 // [R8]
                     COND_IN.door_open, COND_IN.bus_enable,                   // [R7]
                     COND_IN.global_err, COND_IN.running};                    // [R7]

  // Pins are active low at the connector
  assign in_word  = {9'h000, ~REMOTE_IN_N_IN};                 // [R12] [R14] [R15]
  assign out_word = {12'h000, OUTPUT_ACTIVE_IN};               // [R13] [R16]

  assign reg_hit = is_rd_reg && REQ_IN.qty == 16'h0001 &&
                   (REQ_IN.addr == `ADDR_SYS_COND || REQ_IN.addr == `ADDR_REMOTE_INPUT ||
                    REQ_IN.addr == `ADDR_ASSIGNED_OUTPUT);    // [R6] [R10] [R11]
  assign reg_val = (REQ_IN.addr == `ADDR_SYS_COND)     ? sys_word :  // [R6]
                   (REQ_IN.addr == `ADDR_REMOTE_INPUT) ? in_word  :  // [R10]
                   out_word;

  // Coil read: LSB is the first coil asked for
  assign coil_rd_val = 16'(coils_q >> coil_ofs[2:0]) &
                       ~(16'hFFFF << REQ_IN.qty[3:0]);         // [R19]

  ////////////////////////////////////////////////////////////////////////
  // Coil write

  assign wr_mask = is_wr_one ? 5'(5'b00001 << coil_ofs[2:0])
                             : 5'(~(5'b11111 << REQ_IN.qty[2:0]) << coil_ofs[2:0]);
  assign wr_bits = is_wr_one ? {`COIL_COUNT{one_bit}}
                             : 5'(REQ_IN.wdata[4:0] << coil_ofs[2:0]);

  assign req_ok = (is_rd_coil && coil_range_ok) || reg_hit ||
                  (is_wr_one && coil_range_ok && one_val_ok) ||
                  (is_wr_many && coil_range_ok);

  assign coils_d = (REQ_IN.valid && req_ok && (is_wr_one || is_wr_many))
                 ? ((coils_q & ~wr_mask) | (wr_bits & wr_mask))   // [R1] [R19]
                 : coils_q;

  assign rdata_d = is_rd_coil ? coil_rd_val :
                   reg_hit    ? reg_val     :
                   (is_wr_one || is_wr_many) ? REQ_IN.wdata : 16'h0000;

  // A write of 1 to a one-shot coil raises a single request
  assign rev_clr_req = REQ_IN.valid && req_ok && (is_wr_one || is_wr_many)
                     && wr_mask[2] && wr_bits[2];              // [R20] [R3]
  assign scale_load_req = REQ_IN.valid && req_ok && (is_wr_one || is_wr_many)
                        && wr_mask[4] && wr_bits[4];           // [R20] [R5]

  deferred_action u_rev_clr (                                  // [R18]
    .clk_in     (CLK_IN),
    .srst_in    (SRST_IN),
    .req_in     (rev_clr_req),
    .running_in (COND_IN.running),
    .fire_out   (rev_clr_fire)
  );

  deferred_action u_scale_load (                               // [R18]
    .clk_in     (CLK_IN),
    .srst_in    (SRST_IN),
    .req_in     (scale_load_req),
    .running_in (COND_IN.running),
    .fire_out   (scale_load_fire)
  );

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      coils_q <= {`COIL_COUNT{`COIL_RESET}};                   // [R17]
      RSP_OUT <= '0;
      CTRL_OUT <= '0;
    end else begin
      coils_q <= coils_d;
      RSP_OUT.valid <= REQ_IN.valid;
      RSP_OUT.err   <= REQ_IN.valid && !req_ok;
      RSP_OUT.rdata <= (REQ_IN.valid && req_ok) ? rdata_d : 16'h0000;
      CTRL_OUT.run_req   <= coils_d[0];                        // [R2]
      // Rotation and limit changes wait for a stop
      if (!COND_IN.running) begin
        CTRL_OUT.rot_sense <= coils_d[1];                      // [R2] [R18]
        CTRL_OUT.limit_en  <= coils_d[3];                      // [R4] [R18]
      end
      CTRL_OUT.rev_clr_pulse    <= rev_clr_fire;               // [R3]
      CTRL_OUT.scale_load_pulse <= scale_load_fire;            // [R5]
    end
  end

endmodule : pump_fieldbus_map

// file: pump_fieldbus_map_assertions.sv
// Property checker for the pump fieldbus register map
`timescale 1ns/1ps
module pump_fieldbus_map_assertions
  import pump_map_pkg::*;
(
  input wire logic       CLK_IN,
  input wire logic       SRST_IN,
  input wire bus_req_s   REQ_IN,
  input wire pump_cond_s COND_IN,
  input wire logic [6:0] REMOTE_IN_N_IN,
  input wire logic [3:0] OUTPUT_ACTIVE_IN,
  input wire bus_rsp_s   RSP_OUT,
  input wire coil_ctrl_s CTRL_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  wire logic rd4 = REQ_IN.valid && REQ_IN.func == 8'h04 && REQ_IN.qty == 16'h0001;
  wire logic [15:0] sysw = {3'b000, COND_IN.level_alert, COND_IN.high_sp, COND_IN.low_sp,
    COND_IN.tube_burst, 1'b0, COND_IN.stall, COND_IN.over_temp, 2'b00, COND_IN.door_open,
    COND_IN.bus_enable, COND_IN.global_err, COND_IN.running};
  sequence run3;
    COND_IN.running [*3];
  endsequence
  a_rsp_next_cycle: assert property (REQ_IN.valid |=> RSP_OUT.valid)
    else $error("no answer one cycle after request");
  a_sys_word_map: assert property (rd4 && REQ_IN.addr == 16'h0103 |=> RSP_OUT.rdata == $past(sysw))
    else $error("status word wrong");
  a_input_word_map: assert property (rd4 && REQ_IN.addr == 16'h0114 |=>
    RSP_OUT.rdata == {9'h000, ~$past(REMOTE_IN_N_IN)})
    else $error("input word wrong");
  a_output_word_map: assert property (rd4 && REQ_IN.addr == 16'h0115 |=>
    RSP_OUT.rdata == {12'h000, $past(OUTPUT_ACTIVE_IN)})
    else $error("output word wrong");
  a_bad_func_err: assert property (REQ_IN.valid && !(REQ_IN.func inside {8'h01, 8'h04, 8'h05,
    8'h0F}) |=> RSP_OUT.err)
    else $error("bad function not refused");
  a_run_follows: assert property (REQ_IN.valid && REQ_IN.func == 8'h05 && REQ_IN.addr == 16'h02FF
    && REQ_IN.wdata == 16'hFF00 |-> ##[1:2] CTRL_OUT.run_req)
    else $error("run request not set");
  a_clr_one_shot: assert property (CTRL_OUT.rev_clr_pulse |=> !CTRL_OUT.rev_clr_pulse)
    else $error("clear pulse too long");
  a_load_one_shot: assert property (CTRL_OUT.scale_load_pulse |=> !CTRL_OUT.scale_load_pulse)
    else $error("load pulse too long");
  a_hold_while_run: assert property (run3 |-> !CTRL_OUT.scale_load_pulse
    && !CTRL_OUT.rev_clr_pulse && $stable(CTRL_OUT.rot_sense))
    else $error("action while running");
  a_reset_clear: assert property ($fell(SRST_IN) |-> CTRL_OUT == '0)
    else $error("controls not clear after reset");
endmodule : pump_fieldbus_map_assertions

bind pump_fieldbus_map pump_fieldbus_map_assertions chk_i (.CLK_IN, .SRST_IN, .REQ_IN,
  .COND_IN, .REMOTE_IN_N_IN, .OUTPUT_ACTIVE_IN, .RSP_OUT, .CTRL_OUT);

// file: pump_map_params.svh
// Offsets, field positions and widths for the pump fieldbus register map
`ifndef PUMP_MAP_PARAMS_SVH
`define PUMP_MAP_PARAMS_SVH

`define ADDR_SYS_COND        16'h0103
`define ADDR_REMOTE_INPUT    16'h0114
`define ADDR_ASSIGNED_OUTPUT 16'h0115
`define ADDR_RUN_REQ         16'h02FF
`define ADDR_ROT_SENSE       16'h0300
`define ADDR_REV_CLR         16'h0301
`define ADDR_LIMIT_EN        16'h0302
`define ADDR_SCALE_LOAD      16'h0303
`define COIL_FIRST           16'h02FF
`define COIL_COUNT           5

`define FC_READ_COILS        8'h01
`define FC_READ_INPUT_REGS   8'h04
`define FC_WRITE_ONE_COIL    8'h05
`define FC_WRITE_MANY_COILS  8'h0F

`define SYS_BIT_RUNNING      0
`define SYS_BIT_GLOBAL_ERR   1
`define SYS_BIT_BUS_ENABLE   2
`define SYS_BIT_DOOR_OPEN    3
`define SYS_BIT_OVER_TEMP    6
`define SYS_BIT_STALL        7
`define SYS_BIT_TUBE_BURST   9
`define SYS_BIT_LOW_SP       10
`define SYS_BIT_HIGH_SP      11
`define SYS_BIT_LEVEL_ALERT  12

`define IN_BIT_REMOTE        0
`define IN_BIT_STOP          1
`define IN_BIT_START         2
`define IN_BIT_DEST_FULL     3
`define IN_BIT_SRC_EMPTY     4
`define IN_BIT_SPILL         5
`define IN_BIT_CCW           6
`define IN_PIN_COUNT         7
`define OUT_PIN_COUNT        4

`define COIL_RESET           1'b0
`endif

// file: pump_map_pkg.sv
// Types shared by the pump fieldbus register map
package pump_map_pkg;

  typedef struct packed {
    logic        valid;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [15:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [15:0] rdata;
  } bus_rsp_s;

  typedef struct packed {
    logic running;
    logic global_err;
    logic bus_enable;
    logic door_open;
    logic over_temp;
    logic stall;
    logic tube_burst;
    logic low_sp;
    logic high_sp;
    logic level_alert;
  } pump_cond_s;

  typedef struct packed {
    logic run_req;
    logic rot_sense;
    logic limit_en;
    logic rev_clr_pulse;
    logic scale_load_pulse;
  } coil_ctrl_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RESPOND
  } resp_state_e;

endpackage : pump_map_pkg

// file: test_pump_fieldbus_map.sv
// Self-checking bench for the pump fieldbus register map
`timescale 1ns/1ps
module test_pump_fieldbus_map;
  import pump_map_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  pump_cond_s  cond = '0;
  logic [6:0]  rin_n = 7'h7F;
  logic [3:0]  oact = 4'h0;
  bus_req_s    req;
  bus_rsp_s    rsp;
  coil_ctrl_s  ctrl;
  int          fail_count = 0;
  int          total_checks = 0;
  int          nc, nl;
  logic [15:0] rd;
  logic        e, to;
  always #50 clk = ~clk;
  pump_fieldbus_map dut (.CLK_IN(clk), .SRST_IN(srst), .REQ_IN(req), .COND_IN(cond),
    .REMOTE_IN_N_IN(rin_n), .OUTPUT_ACTIVE_IN(oact), .RSP_OUT(rsp), .CTRL_OUT(ctrl));
  fieldbus_master_model m (.clk_in(clk), .rsp_in(rsp), .req_out(req));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] g, x);
    total_checks++;
    if (g !== x) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  task automatic bus(input logic [7:0] f, input logic [15:0] a, q, d);
    m.xfer(f, a, q, d, rd, e, to);
    if (to) begin
      fail_count++;
      report_and_stop();
    end
  endtask : bus
  task automatic pulses;
    nc = 0;
    nl = 0;
    repeat (6) begin
      @(posedge clk);
      #1;
      nc += int'(ctrl.rev_clr_pulse === 1'b1);
      nl += int'(ctrl.scale_load_pulse === 1'b1);
    end
  endtask : pulses
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_status;
    int pos[10] = '{0, 1, 2, 3, 6, 7, 9, 10, 11, 12};
    chk("ctrl", 16'(ctrl), 16'h0000);
    bus(8'h01, 16'h02FF, 16'h0005, 16'h0000);
    chk("coils", rd, 16'h0000);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk) cond <= pump_cond_s'(10'h200 >> i);
      bus(8'h04, 16'h0103, 16'h0001, 16'h0000);
      chk("sys", rd, 16'h0001 << pos[i]);
    end
    @(posedge clk) cond <= '0;
    rin_n <= 7'h55;
    oact <= 4'hA;
    bus(8'h04, 16'h0114, 16'h0001, 16'h0000);
    chk("in", rd, 16'h002A);
    bus(8'h04, 16'h0115, 16'h0001, 16'h0000);
    chk("out", rd, 16'h000A);
    $display("status done");
  endtask : t_status
  task automatic t_coils;
    bus(8'h0F, 16'h02FF, 16'h0005, 16'h000B);
    chk("echo", rd, 16'h000B);
    repeat (2) @(posedge clk);
    #1;
    chk("ctl", {13'h0, ctrl.run_req, ctrl.rot_sense, ctrl.limit_en}, 16'h0007);
    bus(8'h05, 16'h0302, 16'h0001, 16'h0000);
    bus(8'h05, 16'h02FF, 16'h0001, 16'hFF00);
    bus(8'h01, 16'h02FF, 16'h0005, 16'h0000);
    chk("rd", rd, 16'h0003);
    bus(8'h05, 16'h0301, 16'h0001, 16'hFF00);
    pulses();
    chk("clr", 16'(nc), 16'h0001);
    bus(8'h05, 16'h0303, 16'h0001, 16'hFF00);
    pulses();
    chk("load", 16'(nl), 16'h0001);
    bus(8'h05, 16'h0301, 16'h0001, 16'h0000);
    pulses();
    chk("clr0", 16'(nc), 16'h0000);
    $display("coils done");
  endtask : t_coils
  task automatic t_defer;
    @(posedge clk) cond.running <= 1'b1;
    bus(8'h05, 16'h0300, 16'h0001, 16'h0000);
    bus(8'h05, 16'h0303, 16'h0001, 16'hFF00);
    pulses();
    chk("held", {15'h0, ctrl.rot_sense}, 16'h0001);
    chk("held_load", 16'(nl), 16'h0000);
    @(posedge clk) cond.running <= 1'b0;
    pulses();
    chk("late", {15'h0, ctrl.rot_sense}, 16'h0000);
    chk("late_load", 16'(nl), 16'h0001);
    $display("defer done");
  endtask : t_defer
  task automatic t_refuse;
    logic [7:0] f[5] = '{8'h03, 8'h04, 8'h04, 8'h05, 8'h01};
    logic [15:0] a[5] = '{16'h0103, 16'h0104, 16'h0103, 16'h0301, 16'h0300};
    logic [15:0] q[5] = '{16'h0001, 16'h0001, 16'h0002, 16'h0001, 16'h0005};
    for (int i = 0; i < 5; i++) begin
      bus(f[i], a[i], q[i], 16'h1234);
      chk("err", {15'h0, e}, 16'h0001);
    end
    $display("refuse done");
  endtask : t_refuse
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_status();
    t_coils();
    t_defer();
    t_refuse();
    report_and_stop();
  end
endmodule : test_pump_fieldbus_map
